// >>> ddam_pkg.sv
// Shared constants for the run-mode sequencer and register monitor
package ddam_pkg;
   // Clock and iteration rates
   localparam int unsigned CLK_HZ       = 200_000_000;
   localparam int unsigned FAST_RATE_HZ = 100_000;
   localparam int unsigned SLOW_RATE_HZ = 100;
   localparam int unsigned FAST_CYC     = CLK_HZ / FAST_RATE_HZ;
   localparam int unsigned SLOW_CYC     = CLK_HZ / SLOW_RATE_HZ;
   localparam int unsigned HOLD_MULT    = 20;
   // Register byte offsets
   localparam logic [4:0] OFS_STATUS   = 5'h00;
   localparam logic [4:0] OFS_MON_SEL  = 5'h04;
   localparam logic [4:0] OFS_SCALE    = 5'h08;
   localparam logic [4:0] OFS_SYNC_SEL = 5'h0c;
   localparam logic [4:0] OFS_SWITCH   = 5'h10;
   localparam logic [4:0] OFS_MON_DATA = 5'h14;
   // Field positions
   localparam int STS_FAST   = 0;
   localparam int STS_SLOW   = 1;
   localparam int STS_ACTIVE = 2;
   localparam int SEL_BLK_LO = 0;
   localparam int SEL_UNT_LO = 4;
   localparam int SEL_REG_LO = 8;
   localparam int SW_IN_LO   = 0;
   localparam int SW_PUN_LO  = 2;
   // Reset values
   localparam logic [9:0] MON_SEL_RST = 10'h000;
   localparam logic [5:0] SCALE_RST   = 6'h00;
   localparam logic [2:0] SYNC_RST    = 3'h0;
   localparam logic [3:0] SWITCH_RST  = 4'h0;
   // Input selector switch
   localparam logic [1:0] IN_OFF  = 2'h0;
   localparam logic [1:0] IN_AUTO = 2'h1;
   // Punch selector switch
   localparam logic [1:0] PUN_OFF     = 2'h0;
   localparam logic [1:0] PUN_PREPARE = 2'h1;
   localparam logic [1:0] PUN_OUTPUT  = 2'h2;
   // Monitor register selector
   localparam logic [1:0] REG_INIT      = 2'h0;
   localparam logic [1:0] REG_INTEGRAND = 2'h1;
   localparam logic [1:0] REG_OPERAND2  = 2'h2;
   // Monitor shift state
   typedef enum logic {MON_SHIFT = 1'b0, MON_HOLD = 1'b1} ddam_mon_t;
endpackage

// >>> ddam_top.sv
// Run-mode sequencer, increment links and readout monitor with bus registers
// Function
// R1 - Fast mode and positive slow-rate button give positive slow increments at 100/s
// R2 - Fast mode and negative slow-rate button give negative slow increments at 100/s
// R3 - Fast mode computes and emits machine time increments at 100,000/s
// R4 - Fast mode stays latched, lamp lit, until slow or single step pressed
// R5 - Fast mode cannot latch while slow mode is latched
// R6 - Each single step press runs exactly one iteration, never latches
// R7 - Single step press stops fast or slow continuous computation
// R8 - Slow mode computes and emits machine time increments at 100/s
// R9 - Slow mode latched until single step; selecting slow releases fast
// R10 - Increment is existence plus sign; sign 1 positive, sign 0 negative
// R11 - Existence false means no increment; sign then ignored
// R12 - Punch output mode shifts newest selected register in continuously
// R13 - Otherwise hold each capture twenty shift times before refreshing
// R14 - Decimal display only with input off/auto and punch off/prepare
// R15 - Decimal display applies the monitor scale setting
// R16 - Monitor chosen by block, unit and initial/integrand/second operand selector
// R17 - Register shown serially, least significant digit first
// R18 - Exactly one of eight timing signals routed to sync output
// R19 - Integrator/servo take two secondary increments; summer takes six
// R20 - Slow auxiliary output shows no increment outside fast mode
//
// The register addresses and the Avalon-MM register port were left to the implementer.
`timescale 1ns/1ps
module ddam_top
  import ddam_pkg::*;
#(
   parameter int unsigned WORD_W   = 28,
   parameter int unsigned SLOW_CNT = ddam_pkg::SLOW_CYC
)(
   input  wire logic              clk,
   input  wire logic              sys_rst,
   // Avalon-MM slave
   input  wire logic [4:0]        avs_address,
   input  wire logic              avs_read,
   input  wire logic              avs_write,
   input  wire logic [31:0]       avs_writedata,
   output logic [31:0]            avs_readdata,
   output logic                   avs_waitrequest,
   // Front panel
   input  wire logic              fast_btn,
   input  wire logic              slow_btn,
   input  wire logic              step_btn,
   input  wire logic              slow_rate_pos,
   input  wire logic              slow_rate_neg,
   output logic                   fast_lamp,
   output logic                   slow_lamp,
   // Increment links
   output logic                   machine_time_increment_exist,
   output logic                   machine_time_increment_sign,
   output logic                   slow_z_exist,
   output logic                   slow_z_sign,
   input  wire logic [1:0]        sec_exist,
   input  wire logic [1:0]        sec_sign,
   input  wire logic [5:0]        sum_exist,
   input  wire logic [5:0]        sum_sign,
   output logic signed [2:0]      sec_net,
   output logic signed [3:0]      sum_net,
   // Monitor
   input  wire logic [WORD_W-1:0] sel_reg_data,
   input  wire logic              sel_is_multiplier,
   output logic [3:0]             monitor_block,
   output logic [3:0]             monitor_unit,
   output logic [1:0]             monitor_reg,
   output logic                   mon_serial,
   output logic [WORD_W-1:0]      readout,
   output logic                   dec_enable,
   output logic signed [WORD_W-1:0] dec_value,
   // Sync monitoring
   input  wire logic [7:0]        timing_sigs,
   output logic                   sync_out
);
   localparam int FCW = $clog2(FAST_CYC);
   localparam int SCW = $clog2(SLOW_CNT);
   localparam int BCW = $clog2(WORD_W + 1);
   localparam int HCW = $clog2(HOLD_MULT * WORD_W);
   localparam logic [FCW-1:0] FAST_LAST = FCW'(FAST_CYC - 1);
   localparam logic [SCW-1:0] SLOW_LAST = SCW'(SLOW_CNT - 1);
   localparam logic [BCW-1:0] BIT_LAST  = BCW'(WORD_W - 1);
   localparam logic [HCW-1:0] HOLD_LAST = HCW'(HOLD_MULT * WORD_W - 1);

   // Signed value of one existence/sign increment pair
   function automatic logic signed [1:0] inc_val(input logic ex, input logic sg);
      inc_val = !ex ? 2'sd0 : (sg ? 2'sd1 : -2'sd1);
   endfunction

   // Bus registers and handshake state
   logic              wait_q, wait_d;
   logic [31:0]       rdata_q, rdata_d;
   logic [9:0]        mon_sel_q;
   logic [5:0]        scale_q;
   logic [2:0]        sync_sel_q;
   logic [3:0]        switch_q;
   // Mode and rate state
   logic              fast_q, fast_d, slow_q, slow_d, step_prev_q;
   logic [FCW-1:0]    fcnt_q;
   logic [SCW-1:0]    scnt_q;
   logic              mt_ex_q, mt_sg_q, sz_ex_q, sz_sg_q;
   logic signed [2:0] sec_q;
   logic signed [3:0] sum_q;
   // Monitor state
   ddam_mon_t         mon_st_q, mon_st_d;
   logic [BCW-1:0]    bit_q;
   logic [HCW-1:0]    hold_q;
   logic [WORD_W-1:0] shreg_q, readout_q;
   logic              ser_q, dec_en_q, sync_q;
   logic signed [WORD_W-1:0] dec_q;

   // Bus decode; one wait state, then the answer
   wire       req      = avs_read | avs_write;
   wire       wr_take  = avs_write & ~wait_q;
   wire       wr_sel   = wr_take & (avs_address == OFS_MON_SEL);
   wire       wr_scale = wr_take & (avs_address == OFS_SCALE);
   wire       wr_sync  = wr_take & (avs_address == OFS_SYNC_SEL);
   wire       wr_sw    = wr_take & (avs_address == OFS_SWITCH);
   wire [1:0] in_sw    = switch_q[SW_IN_LO +: 2];
   wire [1:0] pun_sw   = switch_q[SW_PUN_LO +: 2];
   wire [1:0] reg_req  = avs_writedata[SEL_REG_LO +: 2];
   // Second operand only exists on the multiplier module
   wire [1:0] reg_ok   = (reg_req == REG_OPERAND2 && !sel_is_multiplier) ?
                         REG_INTEGRAND : reg_req; // R16
   assign wait_d = ~(req & wait_q);

   // Read data mux, unmapped addresses read zero
   always_comb
   begin
      rdata_d = 32'h0000_0000;
      unique case (avs_address)
         OFS_STATUS:
         begin
            rdata_d[STS_FAST]   = fast_q;
            rdata_d[STS_SLOW]   = slow_q;
            rdata_d[STS_ACTIVE] = fast_q | slow_q;
         end
         OFS_MON_SEL:  rdata_d[9:0] = mon_sel_q;
         OFS_SCALE:    rdata_d[5:0] = scale_q;
         OFS_SYNC_SEL: rdata_d[2:0] = sync_sel_q;
         OFS_SWITCH:   rdata_d[3:0] = switch_q;
         OFS_MON_DATA: rdata_d[WORD_W-1:0] = readout_q;
         default:      rdata_d = 32'h0000_0000;
      endcase
   end

   // Bus handshake and configuration registers
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         wait_q     <= 1'b1;
         rdata_q    <= 32'h0000_0000;
         mon_sel_q  <= MON_SEL_RST;
         scale_q    <= SCALE_RST;
         sync_sel_q <= SYNC_RST;
         switch_q   <= SWITCH_RST;
      end
      else
      begin
         wait_q <= wait_d;
         if (avs_read & wait_q)
            rdata_q <= rdata_d;
         if (wr_sel)
            mon_sel_q <= {reg_ok, avs_writedata[7:0]}; // R16
         if (wr_scale)
            scale_q <= avs_writedata[5:0];
         if (wr_sync)
            sync_sel_q <= avs_writedata[2:0];
         if (wr_sw)
            switch_q <= avs_writedata[3:0];
      end
   end

   // Mode latches; single step press releases both
   wire step_rise = step_btn & ~step_prev_q;
   wire fast_tick = (fcnt_q == FAST_LAST);
   wire slow_tick = (scnt_q == SLOW_LAST);
   assign fast_d = (step_rise | slow_btn) ? 1'b0 :            // R4 R7 R9
                   (fast_btn & ~slow_q) ? 1'b1 : fast_q;     // R5
   assign slow_d = step_rise ? 1'b0 : (slow_btn ? 1'b1 : slow_q); // R7 R9
   wire iterate  = (fast_q & fast_tick) | (slow_q & slow_tick) | step_rise; // R3 R6 R8
   wire aux_one  = slow_rate_pos ^ slow_rate_neg;

   // Mode registers and rate dividers
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         fast_q      <= 1'b0;
         slow_q      <= 1'b0;
         step_prev_q <= 1'b0;
         fcnt_q      <= '0;
         scnt_q      <= '0;
      end
      else
      begin
         fast_q      <= fast_d;
         slow_q      <= slow_d;
         step_prev_q <= step_btn; // R6
         fcnt_q      <= fast_tick ? '0 : fcnt_q + 1'b1;
         scnt_q      <= slow_tick ? '0 : scnt_q + 1'b1;
      end
   end

   // Increment outputs and secondary increment sums
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         mt_ex_q <= 1'b0;
         mt_sg_q <= 1'b1;
         sz_ex_q <= 1'b0;
         sz_sg_q <= 1'b0;
         sec_q   <= 3'sd0;
         sum_q   <= 4'sd0;
      end
      else
      begin
         mt_ex_q <= iterate;                         // R10 R11
         mt_sg_q <= 1'b1;
         sz_ex_q <= fast_q & slow_tick & aux_one;    // R1 R2 R20
         sz_sg_q <= slow_rate_pos;                   // R1 R2
         sec_q   <= 3'(inc_val(sec_exist[0], sec_sign[0]))
                  + 3'(inc_val(sec_exist[1], sec_sign[1])); // R19 R11
         sum_q   <= 4'(inc_val(sum_exist[0], sum_sign[0]))
                  + 4'(inc_val(sum_exist[1], sum_sign[1]))
                  + 4'(inc_val(sum_exist[2], sum_sign[2]))
                  + 4'(inc_val(sum_exist[3], sum_sign[3]))
                  + 4'(inc_val(sum_exist[4], sum_sign[4]))
                  + 4'(inc_val(sum_exist[5], sum_sign[5])); // R19
      end
   end

   // Monitor sequencing: shift LSB first, then hold unless punching
   wire shift_end = (mon_st_q == MON_SHIFT) && (bit_q == BIT_LAST);
   wire hold_end  = (mon_st_q == MON_HOLD) && (hold_q == HOLD_LAST);
   wire punch_out = (pun_sw == PUN_OUTPUT);
   wire in_bit    = sel_reg_data[bit_q[BCW-1:0]];
   wire dec_ok    = (in_sw == IN_OFF || in_sw == IN_AUTO) &&
                    (pun_sw == PUN_OFF || pun_sw == PUN_PREPARE); // R14
   wire [WORD_W-1:0] shreg_d = {in_bit, shreg_q[WORD_W-1:1]};   // R17

   always_comb
   begin
      mon_st_d = mon_st_q;
      unique case (mon_st_q)
         MON_SHIFT: if (shift_end && !punch_out) mon_st_d = MON_HOLD; // R12 R13
         MON_HOLD:  if (hold_end || punch_out) mon_st_d = MON_SHIFT;  // R12 R13
      endcase
   end

   // Readout register, serial monitor and decimal view
   always_ff @(posedge clk)
   begin
      if (sys_rst)
      begin
         mon_st_q  <= MON_SHIFT;
         bit_q     <= '0;
         hold_q    <= '0;
         shreg_q   <= '0;
         readout_q <= '0;
         ser_q     <= 1'b0;
         dec_en_q  <= 1'b0;
         dec_q     <= '0;
         sync_q    <= 1'b0;
      end
      else
      begin
         mon_st_q <= mon_st_d;
         bit_q    <= (mon_st_q == MON_SHIFT && !shift_end) ? bit_q + 1'b1 : '0;
         hold_q   <= (mon_st_q == MON_HOLD) ? hold_q + 1'b1 : '0; // R13
         if (mon_st_q == MON_SHIFT)
         begin
            shreg_q <= shreg_d;
            ser_q   <= in_bit; // R17
         end
         if (shift_end)
            readout_q <= shreg_d; // R12
         dec_en_q <= dec_ok;                                     // R14
         dec_q    <= dec_ok ? $signed(readout_q) >>> scale_q : '0; // R15
         sync_q   <= timing_sigs[sync_sel_q];                    // R18
      end
   end

   // Outputs straight from flip-flops
   assign avs_readdata    = rdata_q;
   assign avs_waitrequest = wait_q;
   assign fast_lamp       = fast_q; // R4
   assign slow_lamp       = slow_q; // R9
   assign machine_time_increment_exist = mt_ex_q;
   assign machine_time_increment_sign  = mt_sg_q;
   assign slow_z_exist    = sz_ex_q;
   assign slow_z_sign     = sz_sg_q;
   assign sec_net         = sec_q;
   assign sum_net         = sum_q;
   assign monitor_block   = mon_sel_q[SEL_BLK_LO +: 4]; // R16
   assign monitor_unit    = mon_sel_q[SEL_UNT_LO +: 4];
   assign monitor_reg     = mon_sel_q[SEL_REG_LO +: 2];
   assign mon_serial      = ser_q;
   assign readout         = readout_q;
   assign dec_enable      = dec_en_q;
   assign dec_value       = dec_q;
   assign sync_out        = sync_q;

   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   sequence step_press;
      !step_btn ##1 step_btn;
   endsequence

   fast_latch_a: assert property (fast_btn && !slow_q && !slow_btn && !step_rise
                                   |=> fast_q) // R4
      else $error("fast mode did not latch");
   fast_block_a: assert property (slow_q && !step_rise |=> !fast_q) // R5
      else $error("fast mode latched over slow");
   step_stop_a: assert property (step_press |=> !fast_q && !slow_q) // R7
      else $error("step did not stop computing");
   step_once_a: assert property (step_press ##1 (step_btn && !fast_q && !slow_q)
                                  |=> !mt_ex_q) // R6
      else $error("held step gave extra iteration");
   slow_rel_a: assert property (slow_btn && !step_rise |=> slow_q && !fast_q) // R9
      else $error("slow did not release fast");
   aux_idle_a: assert property (!fast_q |=> !sz_ex_q) // R20
      else $error("slow output active outside fast");
   aux_sign_a: assert property (fast_q && slow_tick && slow_rate_pos && !slow_rate_neg
                                 |=> sz_ex_q && sz_sg_q) // R1
      else $error("positive slow increment missing");
   aux_neg_a: assert property (fast_q && slow_tick && slow_rate_neg && !slow_rate_pos
                                |=> sz_ex_q && !sz_sg_q) // R2
      else $error("negative slow increment missing");
   fast_rate_a: assert property (fast_q && fast_tick && !step_rise |=> mt_ex_q) // R3
      else $error("fast iteration missing");
   // Decimal view blocked the cycle after punch output is seen
   dec_gate_a: assert property (pun_sw == PUN_OUTPUT |=> !dec_en_q) // R14
      else $error("decimal view on while punching");
   // Hold runs its full count unless punching takes over
   hold_len_a: assert property ((mon_st_q == MON_HOLD) && !punch_out
                                 && (hold_q != HOLD_LAST)
                                 |=> (mon_st_q == MON_HOLD)) // R13
      else $error("hold ended too soon");
   sync_sel_a: assert property (##1 sync_q == $past(timing_sigs[sync_sel_q])) // R18
      else $error("sync output mismatch");
endmodule

// >>> ddam_far_model.sv
// Far-side model: computing modules that feed increment pairs to the block
`timescale 1ns/1ps
module ddam_far_model (
   input  wire logic       clk,
   input  wire logic [1:0] sec_pos,
   input  wire logic [1:0] sec_neg,
   input  wire logic [5:0] sum_pos,
   input  wire logic [5:0] sum_neg,
   output logic      [1:0] sec_exist,
   output logic      [1:0] sec_sign,
   output logic      [5:0] sum_exist,
   output logic      [5:0] sum_sign
);
   logic toggle_q = 1'b0;

   // Idle sign lines wander every cycle, so receivers must ignore them
   always_ff @(posedge clk)
   begin
      toggle_q <= ~toggle_q;
   end

   // Existence true for either sign; sign 1 plus, sign 0 minus
   assign sec_exist = sec_pos | sec_neg;
   assign sec_sign  = sec_pos | (~sec_neg & {2{toggle_q}});
   assign sum_exist = sum_pos | sum_neg;
   assign sum_sign  = sum_pos | (~sum_neg & {6{toggle_q}});
endmodule

// >>> dda_run_mode_and_monitor_test.sv
// Self-checking bench for the run-mode sequencer and register monitor
`timescale 1ns/1ps
module dda_run_mode_and_monitor_test;
   import ddam_pkg::*;
   localparam int SLOW_N = 50;
   logic               clk = 1'b0, sys_rst = 1'b1;
   logic [4:0]         avs_address = 5'h00;
   logic               avs_read = 1'b0, avs_write = 1'b0, avs_waitrequest;
   logic [31:0]        avs_writedata = 32'h0000_0000, avs_readdata;
   logic               fast_btn = 1'b0, slow_btn = 1'b0, step_btn = 1'b0;
   logic               slow_rate_pos = 1'b0, slow_rate_neg = 1'b0;
   logic               fast_lamp, slow_lamp, mt_e, mt_s, sz_e, sz_s, mon_serial;
   logic [1:0]         sec_exist, sec_sign, sec_pos = 2'h0, sec_neg = 2'h0, mreg;
   logic [5:0]         sum_exist, sum_sign, sum_pos = 6'h00, sum_neg = 6'h00;
   logic signed [2:0]  sec_net;
   logic signed [3:0]  sum_net;
   logic [27:0]        sel_reg_data = 28'h000_0040, readout, w;
   logic [55:0]        ww;
   logic signed [27:0] dec_value;
   logic               sel_is_multiplier = 1'b0, dec_enable, sync_out;
   logic [3:0]         mblk, munit;
   logic [7:0]         timing_sigs = 8'h00;
   int                 err_count = 0, compares = 0, cycles = 0, g, c1, c2, m;
   logic [1:0]         sp [4] = '{2'h3, 2'h0, 2'h1, 2'h0};
   logic [1:0]         sn [4] = '{2'h0, 2'h3, 2'h2, 2'h0};
   logic [5:0]         up [4] = '{6'h3f, 6'h00, 6'h07, 6'h00};
   logic [5:0]         un [4] = '{6'h00, 6'h3f, 6'h08, 6'h00};
   int                 se [4] = '{2, -2, 0, 0};
   int                 ue [4] = '{6, -6, 2, 0};

   ddam_top #(.WORD_W(28), .SLOW_CNT(SLOW_N)) dut (.clk(clk), .sys_rst(sys_rst),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .fast_btn(fast_btn), .slow_btn(slow_btn),
      .step_btn(step_btn), .slow_rate_pos(slow_rate_pos), .slow_rate_neg(slow_rate_neg),
      .fast_lamp(fast_lamp), .slow_lamp(slow_lamp), .machine_time_increment_exist(mt_e),
      .machine_time_increment_sign(mt_s), .slow_z_exist(sz_e), .slow_z_sign(sz_s),
      .sec_exist(sec_exist), .sec_sign(sec_sign), .sum_exist(sum_exist),
      .sum_sign(sum_sign), .sec_net(sec_net), .sum_net(sum_net),
      .sel_reg_data(sel_reg_data), .sel_is_multiplier(sel_is_multiplier),
      .monitor_block(mblk), .monitor_unit(munit), .monitor_reg(mreg),
      .mon_serial(mon_serial), .readout(readout), .dec_enable(dec_enable),
      .dec_value(dec_value), .timing_sigs(timing_sigs), .sync_out(sync_out));

   ddam_far_model far (.clk(clk), .sec_pos(sec_pos), .sec_neg(sec_neg),
      .sum_pos(sum_pos), .sum_neg(sum_neg), .sec_exist(sec_exist),
      .sec_sign(sec_sign), .sum_exist(sum_exist), .sum_sign(sum_sign));

   // Clock at 200 MHz
   initial
   begin
      forever #2.5 clk = ~clk;
   end

   // Hang guard
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 40000)
      begin
         err_count++;
         results();
      end
   end

   task results();
      if (err_count == 0 && compares > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
      compares++;
      if (s !== e)
      begin
         err_count++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
      end
   endtask

   task tick(input int n);
      repeat (n) @(posedge clk);
   endtask

   // One Avalon transfer, held until waitrequest is sampled low
   task bus(input logic w, input logic [4:0] a, input logic [31:0] d,
            output logic [31:0] q);
      int n;
      n = 0;
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= w;
      avs_read <= ~w;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (avs_waitrequest !== 1'b0);
      q = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      chk("bus wait states", 2, n);
      @(posedge clk);
   endtask

   task wr(input logic [4:0] a, input logic [31:0] d);
      logic [31:0] x;
      bus(1'b1, a, d, x);
   endtask

   task rd(input string nm, input logic [4:0] a, input logic [31:0] e);
      logic [31:0] x;
      bus(1'b0, a, 32'h0000_0000, x);
      chk(nm, e, x);
   endtask

   function automatic logic pulse(input bit z);
      return z ? sz_e : mt_e;
   endfunction

   task count_p(input bit z, input int n, output int c);
      c = 0;
      repeat (n)
      begin
         @(posedge clk);
         if (pulse(z) === 1'b1) c++;
      end
   endtask

   // Cycles between two successive pulses
   task gap(input bit z, output int gv);
      int n;
      n = 0;
      gv = 0;
      do begin @(posedge clk); n++; end while (pulse(z) !== 1'b1 && n < 5000);
      do begin @(posedge clk); gv++; end while (pulse(z) !== 1'b1 && gv < 5000);
   endtask

   // Main sequence
   initial
   begin
      tick(12);
      sys_rst <= 1'b0;
      tick(1);
      for (int i = 0; i < 7; i++) rd("reset value", 5'(i * 4), 32'h0000_0000);
      chk("lamps", 0, {fast_lamp, slow_lamp});
      wr(OFS_STATUS, 32'hffff_ffff);
      wr(5'h18, 32'hffff_ffff);
      rd("status ro", OFS_STATUS, 32'h0000_0000);
      rd("unmapped", 5'h18, 32'h0000_0000);
      fast_btn <= 1'b1; tick(1); fast_btn <= 1'b0; tick(3);
      chk("fast lamp", 1, fast_lamp);
      gap(0, g); chk("fast period", FAST_CYC, g);
      chk("time sign", 1, mt_s);
      slow_rate_pos <= 1'b1;
      gap(1, g); chk("slow z pos period", SLOW_N, g);
      chk("slow z pos sign", 1, sz_s);
      slow_rate_pos <= 1'b0; slow_rate_neg <= 1'b1;
      gap(1, g); chk("slow z neg period", SLOW_N, g);
      chk("slow z neg sign", 0, sz_s);
      slow_rate_neg <= 1'b0; slow_rate_pos <= 1'b1;
      step_btn <= 1'b1; tick(1); step_btn <= 1'b0; tick(3);
      chk("step stops fast", 0, {fast_lamp, slow_lamp});
      count_p(1, 120, c1); chk("slow z idle", 0, c1);
      fast_btn <= 1'b1; tick(1); fast_btn <= 1'b0; tick(3);
      slow_btn <= 1'b1; tick(1); slow_btn <= 1'b0; tick(3);
      chk("slow releases fast", 2'b01, {fast_lamp, slow_lamp});
      count_p(1, 120, c1); chk("slow z in slow", 0, c1);
      gap(0, g); chk("slow period", SLOW_N, g);
      fast_btn <= 1'b1; tick(1); fast_btn <= 1'b0; tick(3);
      chk("fast refused", 2'b01, {fast_lamp, slow_lamp});
      step_btn <= 1'b1; tick(1); step_btn <= 1'b0; tick(3);
      chk("step stops slow", 0, {fast_lamp, slow_lamp});
      slow_rate_pos <= 1'b0;
      tick(100);
      step_btn <= 1'b1; count_p(0, 4, c1); step_btn <= 1'b0; count_p(0, 60, c2);
      chk("single iteration", 1, c1 + c2);
      chk("step unlatched", 0, {fast_lamp, slow_lamp});
      for (int i = 0; i < 4; i++)
      begin
         sec_pos <= sp[i]; sec_neg <= sn[i]; sum_pos <= up[i]; sum_neg <= un[i];
         tick(4);
         chk("sec_net", se[i], 32'(sec_net));
         chk("sum_net", ue[i], 32'(sum_net));
      end
      for (int i = 0; i < 8; i++)
      begin
         wr(OFS_SYNC_SEL, i);
         rd("sync sel", OFS_SYNC_SEL, i);
         timing_sigs <= 8'h01 << i; tick(3); chk("sync on", 1, sync_out);
         timing_sigs <= ~(8'h01 << i); tick(3); chk("sync off", 0, sync_out);
      end
      wr(OFS_MON_SEL, 32'h0000_0295);
      rd("mon sel plain", OFS_MON_SEL, 32'h0000_0195);
      chk("selector pins", 10'h195, {mreg, munit, mblk});
      sel_is_multiplier <= 1'b1; tick(1);
      wr(OFS_MON_SEL, 32'h0000_0295);
      rd("mon sel mult", OFS_MON_SEL, 32'h0000_0295);
      chk("readout held", 28'h000_0040, readout);
      wr(OFS_SCALE, 32'h0000_0002);
      rd("scale", OFS_SCALE, 32'h0000_0002);
      tick(3); chk("dec value", 28'h000_0010, dec_value);
      for (int i = 0; i < 16; i++)
      begin
         wr(OFS_SWITCH, i); tick(2);
         chk("dec enable", i[1:0] < 2 && i[3:2] < 2, dec_enable);
      end
      wr(OFS_SWITCH, 32'h0000_0008);
      sel_reg_data <= 28'h123_4567; tick(70);
      chk("punch tracking", 28'h123_4567, readout);
      // Punch stream bits gathered LSB first must form a rotation of the value
      repeat (28)
      begin
         @(posedge clk);
         w = {mon_serial, w[27:1]};
      end
      ww = {w, w};
      m = 0;
      for (int r = 0; r < 28; r++)
         if (ww[r +: 28] == 28'h123_4567) m = 1;
      chk("serial order", 1, m);
      wr(OFS_SWITCH, 32'h0000_0000);
      sel_reg_data <= 28'h0ab_cdef; tick(1200);
      chk("hold refresh", 28'h0ab_cdef, readout);
      results();
   end
endmodule
